// ===== verif/scfg_chk.sv
// port assertions for the configuration word bank
// assumes a bind into scfg_bank, one clock domain
`timescale 1ns/100ps
`default_nettype none
module scfg_chk #(
    parameter int WORD_BITS = 24
) (
    // clock, reset and pins
    input wire logic        i_sys_clk,
    input wire logic        i_reset_n,
    input wire logic        i_ser_le,
    input wire logic        i_chip_enable,
    // decoded outputs
    input wire logic [11:0] o_if_ref_divider,
    input wire logic        o_if_ref_div_legal,
    input wire logic [4:0]  o_rf_pump_gain_x,
    input wire logic        o_rf_power_down,
    input wire logic        o_if_power_down,
    input wire logic        o_auto_power_up,
    input wire logic        o_w4_fixed_ok,
    input wire logic [23:0] o_extended_fraction_word,
    input wire logic [23:0] o_fastlock_setup_word,
    input wire logic [23:0] o_test_reset_word
);
    ////////////////////////////////////////////////////////////////////////////////
    // saturating count of cycles since the latch pin was last high
    logic [3:0] quiet;
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n || i_ser_le) quiet <= 4'h0;
        else if (quiet != 4'hf) quiet <= quiet + 4'h1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    a_legal_min: assert property (o_if_ref_div_legal |-> o_if_ref_divider >= 12'h003)
        else $error("divider flagged legal below three");
    a_div_quiet: assert property ((!i_ser_le)[*8] |=> $stable(o_if_ref_divider))
        else $error("divider moved without a latch");
    a_gain_range: assert property (o_rf_pump_gain_x != 5'h00 && o_rf_pump_gain_x <= 5'h10)
        else $error("pump gain outside one to sixteen");
    // ce is synchronised, so give it six cycles to reach the outputs
    a_ce_powerdown: assert property ((!i_chip_enable)[*6] |-> o_rf_power_down && o_if_power_down)
        else $error("power down not forced by chip enable");
    a_ext_quiet: assert property ((!i_ser_le)[*8] |=> $stable(o_extended_fraction_word))
        else $error("extended word moved without a latch");
    a_addr_nibbles: assert property (o_extended_fraction_word[3:0] == 4'hb
        && o_fastlock_setup_word[3:0] == 4'hd && o_test_reset_word[3:0] == 4'hf)
        else $error("optional word address nibble wrong");
    a_opt_quiet: assert property (quiet >= 4'ha |-> $stable(o_fastlock_setup_word)
        && $stable(o_test_reset_word))
        else $error("optional word moved while idle");
    a_w4_quiet: assert property (quiet >= 4'ha |-> $stable({o_auto_power_up, o_w4_fixed_ok}))
        else $error("control word outputs moved while idle");
    c_legal: cover property ($rose(o_if_ref_div_legal));
    c_powerup: cover property ($fell(o_rf_power_down));
    c_word7: cover property ($changed(o_test_reset_word));
endmodule // scfg_chk
bind scfg_bank scfg_chk #(.WORD_BITS(WORD_BITS)) chk_u (.i_sys_clk, .i_reset_n, .i_ser_le,
    .i_chip_enable, .o_if_ref_divider, .o_if_ref_div_legal, .o_rf_pump_gain_x,
    .o_rf_power_down, .o_if_power_down, .o_auto_power_up, .o_w4_fixed_ok,
    .o_extended_fraction_word, .o_fastlock_setup_word, .o_test_reset_word);
`default_nettype wire

// ===== verif/scfg_host.sv
// host model driving the three-wire programming pins
// assumes the bank samples pins on i_sys_clk, at least five clocks per level
`timescale 1ns/100ps
`default_nettype none
module scfg_host (
    // clock
    input  wire logic i_sys_clk,
    // serial pins
    output logic      o_ser_clk,
    output logic      o_ser_data,
    output logic      o_ser_le
);
    initial begin
        o_ser_clk = 1'b0;
        o_ser_data = 1'b0;
        o_ser_le = 1'b0;
    end
    // whole 24-bit word, msb first, address in the low nibble
    task automatic send(input logic [23:0] w);
        for (int b = 23; b >= 0; b--) begin
            @(posedge i_sys_clk);
            o_ser_data <= w[b];
            repeat (5) @(posedge i_sys_clk);
            o_ser_clk <= 1'b1;
            repeat (5) @(posedge i_sys_clk);
            o_ser_clk <= 1'b0;
        end
        repeat (5) @(posedge i_sys_clk);
        o_ser_le <= 1'b1;
        repeat (5) @(posedge i_sys_clk);
        o_ser_le <= 1'b0;
        // released data line: show the inverse, not a stale bit
        o_ser_data <= ~w[0];
    endtask
endmodule // scfg_host
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the configuration word bank
// assumes scfg_host drives the serial pins, 20 MHz clock
`timescale 1ns/100ps
`default_nettype none
module tb
    import scfg_pkg::*;
();
    logic i_sys_clk, i_reset_n, i_chip_enable, i_ser_clk, i_ser_data, i_ser_le;
    logic i_rf_dig_lock, i_if_dig_lock, i_rf_ana_lock, i_if_ana_lock;
    logic [3:0] dv;
    logic [11:0] o_if_ref_divider;
    logic [4:0] o_rf_pump_gain_x;
    logic [1:0] o_dither_select, o_modulator_order;
    logic [23:0] o_extended_fraction_word, o_fastlock_setup_word, o_test_reset_word;
    logic o_if_ref_div_legal, o_rf_power_down, o_if_power_down, o_auto_power_up, o_w4_fixed_ok;
    logic o_ref_doubler_enable, o_ref_buffer_out_enable, o_if_pump_polarity, o_rf_pump_polarity;
    logic o_if_prescaler, o_test_lock_pin_out, o_test_lock_pin_oe;
    logic [23:0] m [8];
    logic [19:0] d;
    int fails, n_compared;
    localparam logic [3:0] AD [8] = '{ADDR_W0, ADDR_W1, ADDR_W2, ADDR_W3,
                                      ADDR_W4, ADDR_W5, ADDR_W6, ADDR_W7};
    ////////////////////////////////////////////////////////////////////////////////
    scfg_bank dut_u (.i_sys_clk, .i_reset_n, .i_ser_clk, .i_ser_data, .i_ser_le, .i_chip_enable,
        .i_rf_dig_lock, .i_if_dig_lock, .i_rf_ana_lock, .i_if_ana_lock, .i_if_r_div(dv[0]),
        .i_if_n_div(dv[1]), .i_rf_r_div(dv[2]), .i_rf_n_div(dv[3]), .o_if_ref_divider,
        .o_if_ref_div_legal, .o_rf_pump_gain_x, .o_rf_power_down, .o_if_power_down,
        .o_auto_power_up, .o_dither_select, .o_modulator_order, .o_ref_doubler_enable,
        .o_ref_buffer_out_enable, .o_if_pump_polarity, .o_rf_pump_polarity, .o_if_prescaler,
        .o_extended_fraction_word, .o_fastlock_setup_word, .o_test_reset_word,
        .o_w4_fixed_ok, .o_test_lock_pin_out, .o_test_lock_pin_oe);
    scfg_host host_u (.i_sys_clk, .o_ser_clk(i_ser_clk), .o_ser_data(i_ser_data),
        .o_ser_le(i_ser_le));
    always #25 i_sys_clk = ~i_sys_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (fails == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t seen %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [23:0] ef(input int k);
        return m[3][16+k] ? m[k] : (k == 5 ? DEF_W5 : k == 6 ? DEF_W6 : DEF_W7);
    endfunction
    // model: word0 is never stored, it only triggers the power-up clear
    task automatic wr(input int k, input logic [19:0] v);
        host_u.send({v, AD[k]});
        repeat (12) @(posedge i_sys_clk);
        if (k != 0) m[k] = {v, AD[k]};
        else if (m[4][23] && i_chip_enable) begin
            m[1][23] = 1'b0;
            m[2][23] = 1'b0;
        end
    endtask
    task automatic chk_all();
        chk(o_extended_fraction_word, ef(5));
        chk(o_fastlock_setup_word, ef(6));
        chk(o_test_reset_word, ef(7));
        chk(o_if_ref_divider, m[3][15:4]);
        chk(o_if_ref_div_legal, m[3][15:4] >= 12'h003 && m[3][20]);
        chk(o_rf_pump_gain_x, m[3][19:16] + 5'h01);
        chk({o_rf_power_down, o_if_power_down}, {2{!i_chip_enable}} | {m[1][23], m[2][23]});
        chk({o_auto_power_up, o_dither_select, o_modulator_order, o_ref_doubler_enable,
            o_ref_buffer_out_enable, o_if_pump_polarity, o_rf_pump_polarity, o_if_prescaler},
            {m[4][23], m[4][17:14], m[4][12:8]});
        chk(o_w4_fixed_ok, m[4][22:18] == W4_FIXED && !m[4][13]);
    endtask
    function automatic logic [1:0] pexp(input logic [3:0] s);
        logic [2:0] dl, al;
        dl = {i_if_dig_lock, i_rf_dig_lock, i_rf_dig_lock & i_if_dig_lock};
        al = {i_if_ana_lock, i_rf_ana_lock, i_rf_ana_lock & i_if_ana_lock};
        if (s == 4'h0) return 2'b00;
        if (s < 4'h3) return {1'b1, s == 4'h1};
        if (s < 4'h6) return {1'b1, dl[s-3]};
        if (s < 4'h9) return {~al[s-6], 1'b0};
        return {1'b1, al[s-9]};
    endfunction
    task automatic pulse(input int b);
        @(posedge i_sys_clk);
        dv[b] <= 1'b1;
        repeat (6) @(posedge i_sys_clk);
        dv[b] <= 1'b0;
        repeat (10) @(posedge i_sys_clk);
    endtask
    task automatic pins(input logic [3:0] s);
        logic p;
        logic [1:0] e;
        wr(4, {1'b0, W4_FIXED, 4'hb, 1'b0, 5'h07, s});
        if (s < 4'hc) begin
            for (int k = 0; k < 3; k++) begin
                @(posedge i_sys_clk);
                {i_rf_dig_lock, i_if_dig_lock, i_rf_ana_lock, i_if_ana_lock} <= 4'($urandom);
                repeat (10) @(posedge i_sys_clk);
                e = pexp(s);
                chk({o_test_lock_pin_oe, o_test_lock_pin_out & o_test_lock_pin_oe}, {e[1], &e});
            end
        end else begin
            // selected divider toggles the pin, a neighbour must not
            p = o_test_lock_pin_out;
            pulse(s[1:0]);
            chk({o_test_lock_pin_oe, o_test_lock_pin_out}, {1'b1, ~p});
            pulse(2'(s[1:0] + 2'h1));
            chk({o_test_lock_pin_oe, o_test_lock_pin_out}, {1'b1, ~p});
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge i_sys_clk);
        fails++;
        print_verdict();
    end
    initial begin
        {i_sys_clk, i_reset_n, dv} = '0;
        {i_rf_dig_lock, i_if_dig_lock, i_rf_ana_lock, i_if_ana_lock} = '0;
        i_chip_enable = 1'b1;
        m = '{24'h0, 24'h000003, 24'h000005, RST_W3, RST_W4, DEF_W5, DEF_W6, DEF_W7};
        void'($urandom(32'h9864));
        repeat (5) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        chk(o_extended_fraction_word, 24'h00_000b);
        chk(o_fastlock_setup_word, 24'h00_000d);
        chk(o_test_reset_word, 24'h00_090f);
        chk(o_rf_pump_gain_x, 24'h00_0001);
        for (int i = 0; i < 3; i++) begin
            d = 20'($urandom);
            d[18:14] = W4_FIXED;
            d[9] = (i == 2);
            d[3:0] = 4'h0;
            wr(4, d);
            chk_all();
        end
        for (int i = 0; i < 4; i++) begin
            d = {3'b000, i != 3, 16'($urandom)};
            if (i == 0) d[11:0] = 12'h002;
            if (i == 1) d[15:0] = 16'hf003;
            if (i == 2) d[15:0] = 16'h0fff;
            wr(3, d);
            chk_all();
        end
        for (int k = 5; k < 8; k++) wr(k, 20'($urandom));
        chk_all();
        for (int j = 0; j < 4; j++) begin
            wr(3, {j == 3 ? 3'b111 : 3'(1 << j), 1'b1, 16'($urandom)});
            chk_all();
        end
        // unmapped address must leave every word alone
        host_u.send({20'hf_ffff, 4'h1});
        repeat (12) @(posedge i_sys_clk);
        chk_all();
        for (int s = 0; s < 16; s++) pins(4'(s));
        for (int a = 0; a < 3; a++) begin
            wr(1, {1'b1, 19'($urandom)});
            wr(2, {1'b1, 19'($urandom)});
            i_chip_enable <= (a != 0);
            wr(4, {a < 2, W4_FIXED, 4'h0, 1'b0, 5'h1f, 4'h1});
            chk_all();
            wr(0, 20'($urandom));
            chk_all();
        end
        // reset in mid-run brings every word back to its reset contents
        i_reset_n <= 1'b0;
        repeat (5) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        m = '{24'h0, 24'h000003, 24'h000005, RST_W3, RST_W4, DEF_W5, DEF_W6, DEF_W7};
        // chip enable needs its synchroniser before power down settles
        repeat (8) @(posedge i_sys_clk);
        chk_all();
        print_verdict();
    end
endmodule // tb
`default_nettype wire

// ===== verilog/scfg_bank.sv
// configuration word bank with serial load and test pin select
// assumes serial pins and lock/divider signals arrive asynchronously
`timescale 1ns/100ps
`default_nettype none
module scfg_bank
    import scfg_pkg::*;
#(
    parameter int WORD_BITS = WORD_W
) (
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset_n,
    // serial programming pins and chip enable
    input  wire logic        i_ser_clk,
    input  wire logic        i_ser_data,
    input  wire logic        i_ser_le,
    input  wire logic        i_chip_enable,
    // lock indications
    input  wire logic        i_rf_dig_lock,
    input  wire logic        i_if_dig_lock,
    input  wire logic        i_rf_ana_lock,
    input  wire logic        i_if_ana_lock,
    // divider outputs
    input  wire logic        i_if_r_div,
    input  wire logic        i_if_n_div,
    input  wire logic        i_rf_r_div,
    input  wire logic        i_rf_n_div,
    // decoded configuration
    output logic [11:0]      o_if_ref_divider,
    output logic             o_if_ref_div_legal,
    output logic [4:0]       o_rf_pump_gain_x,
    output logic             o_rf_power_down,
    output logic             o_if_power_down,
    output logic             o_auto_power_up,
    output logic [1:0]       o_dither_select,
    output logic [1:0]       o_modulator_order,
    output logic             o_ref_doubler_enable,
    output logic             o_ref_buffer_out_enable,
    output logic             o_if_pump_polarity,
    output logic             o_rf_pump_polarity,
    output logic             o_if_prescaler,
    output logic [23:0]      o_extended_fraction_word,
    output logic [23:0]      o_fastlock_setup_word,
    output logic [23:0]      o_test_reset_word,
    output logic             o_w4_fixed_ok,
    // test/lock pin
    output logic             o_test_lock_pin_out,
    output logic             o_test_lock_pin_oe
);
    // storage and address decode are built for the 24-bit word only
    if (WORD_BITS != WORD_W) begin : g_bad_width
        $error("scfg_bank: word width must be 24");
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and divider halvers
    logic       ser_clk_s;
    logic       ser_data_s;
    logic       ser_le_s;
    logic       ce_s;
    logic [3:0] lock_s;
    logic [3:0] div_s;
    logic [3:0] div_half;
    logic [3:0] lock_raw;
    logic [3:0] div_raw;

    assign lock_raw = {i_if_ana_lock, i_rf_ana_lock, i_if_dig_lock, i_rf_dig_lock};
    assign div_raw  = {i_rf_n_div, i_rf_r_div, i_if_n_div, i_if_r_div};

    scfg_sync3 u_sclk (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
                       .i_pin(i_ser_clk), .o_level(ser_clk_s));
    scfg_sync3 u_sdat (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
                       .i_pin(i_ser_data), .o_level(ser_data_s));
    scfg_sync3 u_sle  (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
                       .i_pin(i_ser_le), .o_level(ser_le_s));
    scfg_sync3 u_ce   (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
                       .i_pin(i_chip_enable), .o_level(ce_s));

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_in
            scfg_sync3 u_lk (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
                             .i_pin(lock_raw[g]), .o_level(lock_s[g]));
            scfg_sync3 u_dv (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
                             .i_pin(div_raw[g]), .o_level(div_s[g]));
            scfg_halver u_h (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
                             .i_div(div_s[g]), .o_half(div_half[g]));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // serial shift register, msb first
    logic [23:0] shift;
    logic        sclk_d;
    logic        le_d;
    wire         sclk_rise = ser_clk_s && !sclk_d;
    wire         le_rise   = ser_le_s && !le_d;
    wire  [3:0]  wr_addr   = shift[ADDR_W-1:0];

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            shift  <= 24'h00_0000;
            sclk_d <= 1'b0;
            le_d   <= 1'b0;
        end else begin
            sclk_d <= ser_clk_s;
            le_d   <= ser_le_s;
            if (sclk_rise) begin
                shift <= {shift[22:0], ser_data_s};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // word storage; only the addressed word changes on latch, but a word0 latch with auto power-up and ce high clears the power-down bits of word1 and word2
    logic [23:0] word1;
    logic [23:0] word2;
    logic [23:0] word3;
    logic [23:0] word4;
    logic [23:0] word5_raw;
    logic [23:0] word6_raw;
    logic [23:0] word7_raw;

    wire wr_w0 = le_rise && (wr_addr == ADDR_W0);
    wire wr_w1 = le_rise && (wr_addr == ADDR_W1);
    wire wr_w2 = le_rise && (wr_addr == ADDR_W2);
    // auto power-up only while chip enable is high
    wire auto_power_up_clr = wr_w0 && word4[23] && ce_s;

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            word1     <= 24'h00_0003;
            word2     <= 24'h00_0005;
            word3     <= RST_W3;
            word4     <= RST_W4;
            word5_raw <= DEF_W5;
            word6_raw <= DEF_W6;
            word7_raw <= DEF_W7;
        end else begin
            if (wr_w1) begin
                word1 <= shift;
            end
            if (wr_w2) begin
                word2 <= shift;
            end
            if (le_rise && wr_addr == ADDR_W3) begin
                word3 <= shift;
            end
            if (le_rise && wr_addr == ADDR_W4) begin
                word4 <= shift;
            end
            if (le_rise && wr_addr == ADDR_W5) begin
                word5_raw <= shift;
            end
            if (le_rise && wr_addr == ADDR_W6) begin
                word6_raw <= shift;
            end
            if (le_rise && wr_addr == ADDR_W7) begin
                word7_raw <= shift;
            end
            // power-down bits cleared by auto power-up, after any own write
            if (auto_power_up_clr) begin
                word1[RF_PD_BIT] <= 1'b0;
                word2[IF_PD_BIT] <= 1'b0;
            end
        end
    end

    // access bits pick written value or default, each word independently
    wire [23:0] word5 = word3[ACC_W5] ? word5_raw : DEF_W5;
    wire [23:0] word6 = word3[ACC_W6] ? word6_raw : DEF_W6;
    wire [23:0] word7 = word3[ACC_W7] ? word7_raw : DEF_W7;

    ////////////////////////////////////////////////////////////////////////////
    // test/lock pin select
    wire [3:0] sel     = word4[7:4];
    wire       dld_all = lock_s[0] && lock_s[1];
    wire       ald_all = lock_s[2] && lock_s[3];
    logic      pin_val;
    logic      pin_oe;

    always_comb begin
        pin_val = 1'b0;
        pin_oe  = 1'b1;
        unique case (sel)
            SEL_HIZ:     pin_oe  = 1'b0;
            SEL_HIGH:    pin_val = 1'b1;
            SEL_LOW:     pin_val = 1'b0;
            SEL_DLD_ALL: pin_val = dld_all;
            SEL_DLD_RF:  pin_val = lock_s[0];
            SEL_DLD_IF:  pin_val = lock_s[1];
            SEL_OD_ALL:  pin_oe  = !ald_all;
            SEL_OD_RF:   pin_oe  = !lock_s[2];
            SEL_OD_IF:   pin_oe  = !lock_s[3];
            SEL_PP_ALL:  pin_val = ald_all;
            SEL_PP_RF:   pin_val = lock_s[2];
            SEL_PP_IF:   pin_val = lock_s[3];
            SEL_IF_R:    pin_val = div_half[0];
            SEL_IF_N:    pin_val = div_half[1];
            SEL_RF_R:    pin_val = div_half[2];
            SEL_RF_N:    pin_val = div_half[3];
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_if_ref_divider         <= 12'h000;
            o_if_ref_div_legal       <= 1'b0;
            o_rf_pump_gain_x         <= 5'h01;
            o_rf_power_down          <= 1'b1;
            o_if_power_down          <= 1'b1;
            o_auto_power_up          <= 1'b0;
            o_dither_select          <= 2'h0;
            o_modulator_order        <= 2'h0;
            o_ref_doubler_enable     <= 1'b0;
            o_ref_buffer_out_enable  <= 1'b0;
            o_if_pump_polarity       <= 1'b0;
            o_rf_pump_polarity       <= 1'b0;
            o_if_prescaler           <= 1'b0;
            o_extended_fraction_word <= DEF_W5;
            o_fastlock_setup_word    <= DEF_W6;
            o_test_reset_word        <= DEF_W7;
            o_w4_fixed_ok            <= 1'b0;
            o_test_lock_pin_out      <= 1'b0;
            o_test_lock_pin_oe       <= 1'b0;
        end else begin
            o_if_ref_divider         <= word3[15:4];
            o_if_ref_div_legal       <= (word3[15:4] >= IF_R_MIN) && word3[20];
            o_rf_pump_gain_x         <= {1'b0, word3[19:16]} + 5'h01;
            // chip enable low forces both power-down outputs high, whatever the word bits say
            o_rf_power_down          <= !ce_s || word1[RF_PD_BIT];
            o_if_power_down          <= !ce_s || word2[IF_PD_BIT];
            o_auto_power_up          <= word4[23];
            o_dither_select          <= word4[17:16];
            o_modulator_order        <= word4[15:14];
            o_ref_doubler_enable     <= word4[12];
            o_ref_buffer_out_enable  <= word4[11];
            o_if_pump_polarity       <= word4[10];
            o_rf_pump_polarity       <= word4[9];
            o_if_prescaler           <= word4[8];
            o_extended_fraction_word <= word5;
            o_fastlock_setup_word    <= word6;
            o_test_reset_word        <= word7;
            o_w4_fixed_ok            <= (word4[22:18] == W4_FIXED) && !word4[13];
            o_test_lock_pin_out      <= pin_val;
            o_test_lock_pin_oe       <= pin_oe;
        end
    end
endmodule // scfg_bank
`default_nettype wire

// ===== verilog/scfg_halver.sv
// divide-by-two of a divider output pulse stream
// assumes the input is already in the i_sys_clk domain
`timescale 1ns/100ps
`default_nettype none
module scfg_halver (
    // clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_reset_n,
    // divider level and halved copy
    input  wire logic i_div,
    output logic      o_half
);
    logic prev;
    // toggle on each rising edge halves the frequency
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            prev   <= 1'b0;
            o_half <= 1'b0;
        end else begin
            prev <= i_div;
            if (i_div && !prev) begin
                o_half <= ~o_half;
            end
        end
    end
endmodule // scfg_halver
`default_nettype wire

// ===== verilog/scfg_pkg.sv
// constants for the synthesizer configuration register bank
// assumes one system clock; serial pins sampled into that clock
`default_nettype none
package scfg_pkg;
    localparam int          WORD_W      = 24;
    localparam int          ADDR_W      = 4;
    localparam logic [3:0]  ADDR_W0     = 4'h0;
    localparam logic [3:0]  ADDR_W2     = 4'h5;
    localparam logic [3:0]  ADDR_W3     = 4'h7;
    localparam logic [3:0]  ADDR_W4     = 4'h9;
    localparam logic [3:0]  ADDR_W5     = 4'hb;
    localparam logic [3:0]  ADDR_W6     = 4'hd;
    localparam logic [3:0]  ADDR_W7     = 4'hf;
    localparam logic [23:0] DEF_W5      = 24'h00_000b;
    localparam logic [23:0] DEF_W6      = 24'h00_000d;
    localparam logic [23:0] DEF_W7      = 24'h00_090f;
    localparam logic [23:0] RST_W3      = 24'h10_0007;
    // fixed field 01000 in bits 22..18, other fields at their documented defaults
    localparam logic [23:0] RST_W4      = 24'h22_c709;
    localparam logic [4:0]  W4_FIXED    = 5'h08;
    localparam int          ACC_W5      = 21;
    localparam int          ACC_W6      = 22;
    localparam int          ACC_W7      = 23;
    localparam int          IF_PD_BIT   = 23;
    localparam int          RF_PD_BIT   = 23;
    localparam logic [3:0]  ADDR_W1     = 4'h3;
    localparam logic [11:0] IF_R_MIN    = 12'h003;
    localparam logic [3:0]  SEL_HIZ     = 4'h0;
    localparam logic [3:0]  SEL_HIGH    = 4'h1;
    localparam logic [3:0]  SEL_LOW     = 4'h2;
    localparam logic [3:0]  SEL_DLD_ALL = 4'h3;
    localparam logic [3:0]  SEL_DLD_RF  = 4'h4;
    localparam logic [3:0]  SEL_DLD_IF  = 4'h5;
    localparam logic [3:0]  SEL_OD_ALL  = 4'h6;
    localparam logic [3:0]  SEL_OD_RF   = 4'h7;
    localparam logic [3:0]  SEL_OD_IF   = 4'h8;
    localparam logic [3:0]  SEL_PP_ALL  = 4'h9;
    localparam logic [3:0]  SEL_PP_RF   = 4'ha;
    localparam logic [3:0]  SEL_PP_IF   = 4'hb;
    localparam logic [3:0]  SEL_IF_R    = 4'hc;
    localparam logic [3:0]  SEL_IF_N    = 4'hd;
    localparam logic [3:0]  SEL_RF_R    = 4'he;
    localparam logic [3:0]  SEL_RF_N    = 4'hf;
endpackage
`default_nettype wire

// ===== verilog/scfg_sync3.sv
// three-stage synchroniser for a pin input
// assumes the pin is asynchronous to i_sys_clk
`timescale 1ns/100ps
`default_nettype none
module scfg_sync3 (
    // clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_reset_n,
    // pin and filtered level
    input  wire logic i_pin,
    output logic      o_level
);
    logic s1;
    logic s2;
    logic s3;
    // change accepted only when stages two and three agree
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            s1      <= 1'b0;
            s2      <= 1'b0;
            s3      <= 1'b0;
            o_level <= 1'b0;
        end else begin
            s1 <= i_pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                o_level <= s3;
            end
        end
    end
endmodule // scfg_sync3
`default_nettype wire
